/* src/pabe_adc_backend.v */
// Notes on behaviour
// - track/hold samples on edge, holds next phase
// - nine stages, two bits each, residue onward
// - stages advance in pairs, two stages per conversion clock
// - delay lines on all but the last stage align codes of one sample
// - error correction merges redundant bits, 10-bit word
// - word valid five clocks after its sample
// - straight offset binary, full scale all ones
// - active-low output control high floats outputs
// - control low or unconnected drives outputs
// - power down floats; next five words invalid
// - top result bit on highest data line
`timescale 1ns/1ps
`include "pabe_adc_regs.vh"

module pabe_adc_backend #(
    parameter SAMPLE_W = `PABE_SAMPLE_W,
    parameter RESULT_W = `PABE_RESULT_W
) (
    input wire i_ref_clk,
    input wire i_srst,
    input wire [SAMPLE_W-1:0] i_sample,
    input wire i_out_en_n,
    input wire i_pwr_down,
    output wire [RESULT_W-1:0] o_result,
    output wire o_result_oe,
    output wire o_result_valid
);

    // ****************************************************************
    // stage arithmetic
    // ****************************************************************
    localparam [SAMPLE_W-1:0] FS_HALF = {1'b1, {(SAMPLE_W-1){1'b0}}};
    localparam [SAMPLE_W-1:0] LO_THR = {3'b011, {(SAMPLE_W-3){1'b0}}};
    localparam [SAMPLE_W-1:0] HI_THR = {3'b101, {(SAMPLE_W-3){1'b0}}};
    localparam NST = `PABE_STAGES;
    localparam CW = `PABE_CODE_W;
    localparam [`PABE_CNT_W-1:0] LAT = `PABE_LATENCY;

    // redundant decision with thresholds at 3/8 and 5/8 of full scale
    function [CW-1:0] stage_code;
        input [SAMPLE_W-1:0] x;
        begin
            if (x < LO_THR)
                stage_code = 2'h0;
            else if (x < HI_THR)
                stage_code = 2'h1;
            else
                stage_code = 2'h2;
        end
    endfunction

    // residue = 2x - code * fs/2, always lands inside [0, fs)
    function [SAMPLE_W-1:0] stage_residue;
        input [SAMPLE_W-1:0] x;
        input [CW-1:0] code;
        reg [SAMPLE_W:0] dbl;
        reg [SAMPLE_W:0] sub;
        begin
            dbl = {x, 1'b0};
            sub = {1'b0, FS_HALF} * {{(SAMPLE_W-1){1'b0}}, code};
            stage_residue = dbl[SAMPLE_W-1:0] - sub[SAMPLE_W-1:0];
        end
    endfunction

    // overlapping shift-add; stage i weighs 2^(8-i), last stage weighs 1
    function [RESULT_W-1:0] correct;
        input [NST*CW-1:0] codes;
        reg [RESULT_W:0] acc;
        integer i;
        begin
            acc = {(RESULT_W+1){1'b0}};
            for (i = 0; i < NST; i = i + 1)
                acc = acc + ({{(RESULT_W-1){1'b0}}, codes[i*CW +: CW]} << (NST-1-i));
            if (acc > {1'b0, `PABE_RESULT_MAX})
                correct = `PABE_RESULT_MAX;
            else
                correct = acc[RESULT_W-1:0];
        end
    endfunction

    // ****************************************************************
    // track/hold
    // ****************************************************************
    reg [SAMPLE_W-1:0] hold_reg;

    // sample at edge
    // the edge closes the sampling phase; the held value feeds stage 0
    // through the whole following phase
    always @(posedge i_ref_clk)
    begin
        if (i_srst)
            hold_reg <= {SAMPLE_W{1'b0}};
        else
            hold_reg <= i_sample;
    end

    // ****************************************************************
    // quantizer pipeline, two stages per clock
    // ****************************************************************
    wire [SAMPLE_W-1:0] stage_in [0:NST-1];
    wire [SAMPLE_W-1:0] stage_out [0:NST-1];
    wire [CW-1:0] code_w [0:NST-1];
    wire [NST*CW-1:0] aligned;
    reg [SAMPLE_W-1:0] res_reg [0:3];

    genvar g;
    generate
        for (g = 0; g < NST; g = g + 1)
        begin : stg
            if (g == 0)
            begin : first
                assign stage_in[g] = hold_reg;
            end
            else if (g % 2 == 0)
            begin : even
                assign stage_in[g] = res_reg[g/2-1];
            end
            else
            begin : odd
                assign stage_in[g] = stage_out[g-1];
            end

            if (g == NST-1)
            begin : fine
                // last stage flash
                // final stage has no redundancy; its two msbs are the code
                assign code_w[g] = stage_in[g][SAMPLE_W-1 -: CW];
                assign stage_out[g] = {SAMPLE_W{1'b0}};
            end
            else
            begin : coarse
                assign code_w[g] = stage_code(stage_in[g]);
                assign stage_out[g] = stage_residue(stage_in[g], code_w[g]);
            end

            if (g % 2 == 1 && g < NST-1)
            begin : pipe
                always @(posedge i_ref_clk)
                begin
                    if (i_srst)
                        res_reg[g/2] <= {SAMPLE_W{1'b0}};
                    else
                        res_reg[g/2] <= stage_out[g];
                end
            end

            if (g == NST-1)
            begin : tail
                // last code unwaited
                // the last stage resolves in the cycle the word is built;
                // any delay here would pair it with the next sample
                assign aligned[g*CW +: CW] = code_w[g];
            end
            else
            begin : wait_line
                // align stage codes
                // pair p resolves one clock after pair p-1, so it waits one less
                pabe_delay_line #(
                    .WIDTH(CW),
                    .DEPTH(`PABE_ALIGN_DEPTH - g/2)
                ) pabe_delay_line_i (
                    .i_ref_clk(i_ref_clk),
                    .i_srst(i_srst),
                    .i_data(code_w[g]),
                    .o_data(aligned[g*CW +: CW])
                );
            end
        end
    endgenerate

    // ****************************************************************
    // correction and output drive
    // ****************************************************************
    reg [RESULT_W-1:0] result_reg;
    reg oe_reg;
    reg valid_reg;
    reg [`PABE_CNT_W-1:0] fill_reg;
    reg [`PABE_CNT_W-1:0] fill_next;

    // refill after power down
    // the pipeline contents are garbage while powered down, so the
    // fill count restarts and the next five words are flagged invalid
    always @*
    begin
        if (i_pwr_down)
            fill_next = {`PABE_CNT_W{1'b0}};
        else if (fill_reg != LAT)
            fill_next = fill_reg + 3'h1;
        else
            fill_next = fill_reg;
    end

    always @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            result_reg <= {RESULT_W{1'b0}};
            oe_reg <= 1'b0;
            valid_reg <= 1'b0;
            fill_reg <= {`PABE_CNT_W{1'b0}};
        end
        else
        begin
            result_reg <= correct(aligned);
            oe_reg <= ~i_out_en_n & ~i_pwr_down;
            valid_reg <= (fill_reg == LAT) & ~i_pwr_down;
            fill_reg <= fill_next;
        end
    end

    // top bit on top line
    // code zero is the most negative input; the sum rises with the input
    assign o_result = result_reg;
    assign o_result_oe = oe_reg;
    assign o_result_valid = valid_reg;

endmodule

/* src/pabe_adc_regs.vh */
`ifndef PABE_ADC_REGS_VH
`define PABE_ADC_REGS_VH

// ****************************************************************
// result word
// ****************************************************************
`define PABE_RESULT_W 10
`define PABE_RESULT_TOP_BIT 9
`define PABE_RESULT_BOTTOM_BIT 0
`define PABE_RESULT_MAX 10'h3ff

// ****************************************************************
// quantizer pipeline
// ****************************************************************
`define PABE_STAGES 9
`define PABE_CODE_W 2
`define PABE_STAGES_PER_CYCLE 2
`define PABE_ALIGN_DEPTH 4
`define PABE_SAMPLE_W 12

// ****************************************************************
// timing counts, in conversion clock cycles
// ****************************************************************
`define PABE_LATENCY 3'h5
`define PABE_CNT_W 3

`endif

/* src/pabe_delay_line.v */
`timescale 1ns/1ps

// ****************************************************************
// fixed-depth delay line for one stage code
// ****************************************************************
module pabe_delay_line #(
    parameter WIDTH = 2,
    parameter DEPTH = 1
) (
    input wire i_ref_clk,
    input wire i_srst,
    input wire [WIDTH-1:0] i_data,
    output wire [WIDTH-1:0] o_data
);

    // depth must be at least one; a zero depth leaves o_data on a tap that is never loaded
    reg [WIDTH-1:0] tap_reg [0:DEPTH-1];
    integer k;

    always @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            for (k = 0; k < DEPTH; k = k + 1)
                tap_reg[k] <= {WIDTH{1'b0}};
        end
        else
        begin
            tap_reg[0] <= i_data;
            for (k = 1; k < DEPTH; k = k + 1)
                tap_reg[k] <= tap_reg[k-1];
        end
    end

    assign o_data = tap_reg[DEPTH-1];

endmodule

/* test/pabe_adc_backend_bench.sv */
`timescale 1ns/1ps
// ********************
// bench
// ********************
module pabe_adc_backend_bench;
    reg i_ref_clk = 1'b0;
    reg i_srst = 1'b1;
    reg [11:0] i_sample = 12'h000;
    reg i_out_en_n = 1'b0;
    reg i_pwr_down = 1'b0;
    wire [9:0] o_result;
    wire o_result_oe;
    wire o_result_valid;
    wire [9:0] word;
    wire ok;
    integer miscompares = 0;
    integer comparisons = 0;
    integer cycles = 0;
    reg [11:0] hist[$];
    // floated bus reads inverted so a stale word cannot match
    wire [9:0] bus = o_result_oe ? o_result : ~o_result;
    always #12.5 i_ref_clk = ~i_ref_clk;
    pabe_adc_backend pabe_adc_backend_i (.i_ref_clk, .i_srst, .i_sample, .i_out_en_n,
        .i_pwr_down, .o_result, .o_result_oe, .o_result_valid);
    pabe_host_capture pabe_host_capture_i (.i_ref_clk, .i_bus(bus), .i_oe(o_result_oe),
        .i_valid(o_result_valid), .o_word(word), .o_ok(ok));
    always @(posedge i_ref_clk)
    begin
        cycles = cycles + 1;
        if (cycles == 500)
        begin
            miscompares = miscompares + 1;
            end_of_test;
        end
    end
    task chk_word(input string nm, input [9:0] exp, input [9:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp)
            begin
                miscompares = miscompares + 1;
                $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    task chk_flag(input string nm, input exp, input got);
        chk_word(nm, {9'h000, exp}, {9'h000, got});
    endtask
    // the next edge takes the sample now on the pins
    task resync;
        begin
            hist.delete();
            hist.push_back(i_sample);
        end
    endtask
    task step(input [11:0] s);
        reg [11:0] old;
        begin
            @(negedge i_ref_clk);
            i_sample = s;
            hist.push_back(s);
            if (hist.size() > 7)
            begin
                old = hist.pop_front();
                chk_flag("ok", 1'b1, ok);
                chk_word("word", old[11:2], word);
            end
        end
    endtask
    task t_stream;
        integer i;
        begin
            for (i = 0; i < 24; i = i + 1)
                step(i == 1 ? 12'hfff : 12'(i) * 12'h0b3);
            $display("t_stream done");
        end
    endtask
    task t_float;
        begin
            @(negedge i_ref_clk);
            i_out_en_n = 1'b1;
            @(negedge i_ref_clk);
            chk_flag("oe", 1'b0, o_result_oe);
            i_out_en_n = 1'b0;
            @(negedge i_ref_clk);
            chk_flag("oe", 1'b1, o_result_oe);
            $display("t_float done");
        end
    endtask
    task t_pwrdown;
        integer i;
        begin
            @(negedge i_ref_clk);
            i_pwr_down = 1'b1;
            repeat (3) @(negedge i_ref_clk);
            chk_flag("oe", 1'b0, o_result_oe);
            chk_flag("valid", 1'b0, o_result_valid);
            i_pwr_down = 1'b0;
            resync;
            for (i = 0; i < 14; i = i + 1)
            begin
                step(12'h800 + 12'(i));
                if (i < 5)
                    chk_flag("valid", 1'b0, o_result_valid);
                else if (i == 5)
                    chk_flag("valid", 1'b1, o_result_valid);
            end
            $display("t_pwrdown done");
        end
    endtask
    task end_of_test;
        begin
            $display("comparisons %0d miscompares %0d", comparisons, miscompares);
            if (miscompares == 0 && comparisons > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    initial
    begin
        repeat (3) @(negedge i_ref_clk);
        i_srst = 1'b0;
        resync;
        t_stream;
        t_float;
        t_pwrdown;
        end_of_test;
    end
endmodule

/* test/pabe_adc_props.sv */
`timescale 1ns/1ps
// ********************
// port checker
// ********************
module pabe_adc_props #(
    parameter SAMPLE_W = 12,
    parameter RESULT_W = 10
) (
    input wire i_ref_clk,
    input wire i_srst,
    input wire [SAMPLE_W-1:0] i_sample,
    input wire i_out_en_n,
    input wire i_pwr_down,
    input wire [RESULT_W-1:0] o_result,
    input wire o_result_oe,
    input wire o_result_valid
);
    wire [9:0] s_top = i_sample[SAMPLE_W-1:SAMPLE_W-10];
    wire s_msb = i_sample[SAMPLE_W-1];
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);
    property p_float; $past(i_out_en_n) && !$past(i_srst) |-> !o_result_oe; endproperty
    a_float: assert property (p_float) else $error("bus driven while floated");
    property p_drive; !$past(i_out_en_n) && !$past(i_pwr_down) && !$past(i_srst) |-> o_result_oe;
    endproperty
    a_drive: assert property (p_drive) else $error("bus not driven");
    property p_pd; $past(i_pwr_down) |-> !o_result_oe && !o_result_valid; endproperty
    a_pd: assert property (p_pd) else $error("outputs live in power-down");
    property p_pd_fill; $fell(i_pwr_down) |-> !o_result_valid [*6] ##1 o_result_valid; endproperty
    a_pd_fill: assert property (p_pd_fill) else $error("wrong refill after power-down");
    property p_rst_fill; $fell(i_srst) |-> !o_result_valid [*6] ##1 o_result_valid; endproperty
    a_rst_fill: assert property (p_rst_fill) else $error("wrong fill after reset");
    property p_data; o_result_valid |-> o_result == $past(s_top, 6); endproperty
    a_data: assert property (p_data) else $error("word not from sample five back");
    property p_msb; o_result_valid |-> o_result[9] == $past(s_msb, 6); endproperty
    a_msb: assert property (p_msb) else $error("top result bit misplaced");
    property p_step; o_result_valid && $past(o_result_valid) &&
        $past(s_top, 6) != $past(s_top, 7) |-> $changed(o_result); endproperty
    a_step: assert property (p_step) else $error("word not updated");
    c_full: cover property (o_result_valid && o_result == 10'h3ff);
    c_float: cover property ($rose(i_out_en_n));
    c_pd: cover property ($fell(i_pwr_down));
endmodule

bind pabe_adc_backend pabe_adc_props #(.SAMPLE_W(SAMPLE_W), .RESULT_W(RESULT_W)) pabe_adc_props_i (
    .i_ref_clk, .i_srst, .i_sample, .i_out_en_n, .i_pwr_down,
    .o_result, .o_result_oe, .o_result_valid);

/* test/pabe_host_capture.sv */
`timescale 1ns/1ps
// ********************
// host capture logic
// ********************
module pabe_host_capture (
    input wire i_ref_clk,
    input wire [9:0] i_bus,
    input wire i_oe,
    input wire i_valid,
    output reg [9:0] o_word,
    output reg o_ok
);
    always @(posedge i_ref_clk)
    begin
        o_word <= i_bus;
        o_ok <= i_oe && i_valid;
    end
endmodule
